// File: pkg/brt_consts.svh
// Constants for the byte-wide real-time clock block
//
// Function
// - Counters kept apart from host-visible copies
// - Freeze bit stops copies into time registers
// - Frozen copies hold count at freeze instant
// - All copies refresh together; updates finish
// - Refresh resumes within one second after freeze
// - Load bit also freezes copies for setting
// - Clearing load bit copies registers into counters
// - Halt bit stops oscillator; restarts when cleared
// - Battery-low flag is read only
// - Century flag toggles at rollover when enabled
// - Century enable writable anytime; flag needs load
// - Trim magnitude bits 4:0, sign bit 5
// - Trim blanks or splits divide-by-256 pulses
// - 64-minute trim cycle, one second per minute
// - Magnitude N trims first 2N minutes
// - Seconds derived from 32768 Hz oscillator
// - Test output toggles 512 Hz when enabled
// - Power-up check sets battery-low when enabled
// - Battery-low stays until a check passes
// - Battery checks only with main supply present
`ifndef BRT_CONSTS_SVH
`define BRT_CONSTS_SVH

// Register addresses in the memory map
`define BRT_ADDR_W 13
`define BRT_ADDR_CTRL 13'h1ff8
`define BRT_ADDR_SEC 13'h1ff9
`define BRT_ADDR_MIN 13'h1ffa
`define BRT_ADDR_HOUR 13'h1ffb
`define BRT_ADDR_CWDAY 13'h1ffc
`define BRT_ADDR_DATE 13'h1ffd
`define BRT_ADDR_MONTH 13'h1ffe
`define BRT_ADDR_YEAR 13'h1fff
`define BRT_ADDR_BASE_HI 10'h3ff

// Field positions
`define BRT_CTRL_LOAD 7
`define BRT_CTRL_FREEZE 6
`define BRT_CTRL_SIGN 5
`define BRT_SEC_HALT 7
`define BRT_CW_PROBE 6
`define BRT_CW_CEN_ON 5
`define BRT_CW_CEN 4
`define BRT_DATE_WATCH 7
`define BRT_DATE_BLOW 6

// Oscillator divider and trim figures
`define BRT_OSC_HZ 32768
`define BRT_STAGE_DIV 256
`define BRT_PRE_LAST 8'hff
`define BRT_PRE_SPLIT 8'h7f
`define BRT_STAGE_LAST 7'h7f
`define BRT_PROBE_BIT 5

// Reset values; oscillator starts halted
`define BRT_RST_CTRL 8'h00
`define BRT_RST_HALT 1'b1
`define BRT_RST_WDAY 3'h1
`define BRT_RST_DATE 6'h01
`define BRT_RST_MONTH 5'h01

`endif

// File: pkg/brt_pkg.sv
// Types for the byte-wide real-time clock block
package brt_pkg;

  // One full BCD time value
  typedef struct packed {
    logic century;
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] date;
    logic [2:0] wday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } brt_time_t;

  // Complete state of the block
  typedef struct packed {
    brt_time_t cnt;
    brt_time_t shadow;
    logic [7:0] ctrl;
    logic halt;
    logic probe_on;
    logic cen_on;
    logic watch_on;
    logic blow;
    logic [7:0] pre;
    logic [6:0] stage;
    logic [5:0] cal_min;
    logic cal_done;
    logic acc_prev;
    logic vcc_prev;
    logic [7:0] rd_data;
    logic rd_oe;
    logic hit;
    logic probe_oe;
  } brt_state_t;

endpackage : brt_pkg

// File: hw/brt_top.sv
// Real-time clock counters and register bytes at the top of the memory map
`timescale 1ns/1ns
`default_nettype none
`include "brt_consts.svh"

module brt_top (
  input wire logic clock, // 250 MHz system clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [12:0] addr, // Byte address
  input wire logic [7:0] data_in, // Write data
  input wire logic chip_en_n, // Chip enable, active low
  input wire logic write_en_n, // Write enable, active low
  input wire logic out_en_n, // Output enable, active low
  input wire logic osc_pulse, // One pulse per 32768 Hz oscillator cycle
  input wire logic vcc_good, // Main supply at nominal level
  input wire logic batt_below, // Battery comparator says low
  output logic [7:0] data_out, // Read data
  output logic data_oe, // Read data drives bus
  output logic clk_hit, // Access falls in clock bytes
  output logic freq_probe_o, // Test pin level when driven
  output logic freq_probe_oe // Test pin pulled low
);

  brt_pkg::brt_state_t q, d;

  // Packed BCD increment with wrap; bit 8 flags the wrap
  function automatic logic [8:0] bcd_next(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    logic [8:0] r;
    r = 9'h000;
    if (v >= hi) begin
      r = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v + 8'h01};
    end
    return r;
  endfunction : bcd_next

  // Last BCD date of a month; leap years by four-year rule on two digits
  function automatic logic [7:0] month_last(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    logic [7:0] r;
    leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
           (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
    r = 8'h31;
    unique case (m)
      5'h02: r = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction : month_last

  // Advance the running count by one second
  function automatic brt_pkg::brt_time_t time_step(input brt_pkg::brt_time_t t,
                                                   input logic cen_on);
    brt_pkg::brt_time_t n;
    logic [8:0] s;
    n = t;
    s = bcd_next({1'b0, t.sec}, 8'h00, 8'h59);
    n.sec = s[6:0];
    if (s[8]) begin
      s = bcd_next({1'b0, t.min}, 8'h00, 8'h59);
      n.min = s[6:0];
      if (s[8]) begin
        s = bcd_next({2'b00, t.hour}, 8'h00, 8'h23);
        n.hour = s[5:0];
        if (s[8]) begin
          s = bcd_next({5'h00, t.wday}, 8'h01, 8'h07);
          n.wday = s[2:0];
          s = bcd_next({2'b00, t.date}, 8'h01, month_last(t.month, t.year));
          n.date = s[5:0];
          if (s[8]) begin
            s = bcd_next({3'h0, t.month}, 8'h01, 8'h12);
            n.month = s[4:0];
            if (s[8]) begin
              s = bcd_next(t.year, 8'h00, 8'h99);
              n.year = s[7:0];
              // Century flag flips only when enabled
              if (s[8] && cen_on) begin
                n.century = ~t.century;
              end
            end
          end
        end
      end
    end
    return n;
  endfunction : time_step

  logic acc_now;
  logic wr_take;
  logic rd_take;
  logic hit_now;
  logic frozen;
  logic osc_run;
  logic stage_pulse;
  logic sec_tick;
  logic affected;
  logic load_now;
  logic [5:0] trim_span;
  logic [7:0] rd_mux;

  // Access decode: only the top eight addresses belong to the clock
  always_comb begin
    hit_now = (addr[12:3] == `BRT_ADDR_BASE_HI);
    acc_now = !chip_en_n && !write_en_n && hit_now;
    rd_take = !chip_en_n && !out_en_n && write_en_n && hit_now;
    // Write taken once, on the cycle the strobe first becomes active
    wr_take = acc_now && !q.acc_prev;
    frozen = q.ctrl[`BRT_CTRL_FREEZE] || q.ctrl[`BRT_CTRL_LOAD];
    trim_span = {q.ctrl[4:0], 1'b0};
  end

  // Read view; reserved positions read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr[2:0])
      3'h0: rd_mux = q.ctrl;
      3'h1: rd_mux = {q.halt, q.shadow.sec};
      3'h2: rd_mux = {1'b0, q.shadow.min};
      3'h3: rd_mux = {2'b00, q.shadow.hour};
      3'h4: rd_mux = {1'b0, q.probe_on, q.cen_on, q.shadow.century, 1'b0, q.shadow.wday};
      3'h5: rd_mux = {q.watch_on, q.blow, q.shadow.date};
      3'h6: rd_mux = {3'h0, q.shadow.month};
      3'h7: rd_mux = q.shadow.year;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    load_now = 1'b0;
    stage_pulse = 1'b0;
    sec_tick = 1'b0;

    // Oscillator gated by the halt bit
    osc_run = osc_pulse && !q.halt;
    // Trim hits the first second of the first 2N minutes of the cycle
    affected = (q.cal_min < trim_span) && (q.cnt.sec == 7'h00) && !q.cal_done;

    // Divide-by-256 stage with pulse blanking or splitting
    if (osc_run) begin
      d.pre = q.pre + 8'h01;
      if (q.pre == `BRT_PRE_LAST) begin
        if (affected && (q.stage == 7'h00) && !q.ctrl[`BRT_CTRL_SIGN]) begin
          d.cal_done = 1'b1;
        end else begin
          stage_pulse = 1'b1;
        end
      end else if (q.pre == `BRT_PRE_SPLIT && affected && (q.stage == 7'h00) &&
                   q.ctrl[`BRT_CTRL_SIGN]) begin
        // Extra stage pulse half way through: second is 128 cycles short
        stage_pulse = 1'b1;
        d.pre = 8'h00;
        d.cal_done = 1'b1;
      end
    end

    // 128 stage pulses make one second
    if (stage_pulse) begin
      d.stage = q.stage + 7'h01;
      if (q.stage == `BRT_STAGE_LAST) begin
        sec_tick = 1'b1;
      end
    end

    // Running count advances regardless of any freeze
    if (sec_tick) begin
      d.cnt = time_step(q.cnt, q.cen_on);
      d.cal_done = 1'b0;
      if (q.cnt.sec == 7'h59) begin
        d.cal_min = q.cal_min + 6'h01;
      end
      // Whole copy in one cycle; a freeze written now waits for it
      if (!frozen) begin
        d.shadow = d.cnt;
      end
    end

    // Host writes into the clock bytes, reserved bits dropped
    if (wr_take) begin
      unique case (addr[2:0])
        3'h0: begin
          d.ctrl = data_in;
          // Load bit falling: copied values become the running count
          if (q.ctrl[`BRT_CTRL_LOAD] && !data_in[`BRT_CTRL_LOAD]) begin
            load_now = 1'b1;
          end
        end
        3'h1: begin
          d.halt = data_in[`BRT_SEC_HALT];
          d.shadow.sec = data_in[6:0];
        end
        3'h2: d.shadow.min = data_in[6:0];
        3'h3: d.shadow.hour = data_in[5:0];
        3'h4: begin
          d.probe_on = data_in[`BRT_CW_PROBE];
          d.cen_on = data_in[`BRT_CW_CEN_ON];
          d.shadow.wday = data_in[2:0];
          // Century flag only takes a write while loading
          if (q.ctrl[`BRT_CTRL_LOAD]) begin
            d.shadow.century = data_in[`BRT_CW_CEN];
          end
        end
        3'h5: begin
          d.watch_on = data_in[`BRT_DATE_WATCH];
          d.shadow.date = data_in[5:0];
        end
        3'h6: d.shadow.month = data_in[4:0];
        3'h7: d.shadow.year = data_in;
      endcase
    end

    // Load wins over a tick in the same cycle; divider restarts
    if (load_now) begin
      d.cnt = q.shadow;
      d.pre = 8'h00;
      d.stage = 7'h00;
      d.cal_done = 1'b0;
    end

    // Battery check at each power-up, only on main supply
    d.vcc_prev = vcc_good;
    if (vcc_good && !q.vcc_prev) begin
      if (q.watch_on && batt_below) begin
        d.blow = 1'b1;
      end else if (!batt_below) begin
        d.blow = 1'b0;
      end
    end

    // Bus side registered outputs
    d.acc_prev = acc_now;
    d.hit = hit_now && !chip_en_n;
    d.rd_oe = rd_take;
    d.rd_data = rd_take ? rd_mux : 8'h00;

    // Open-drain probe: pulls low on the low half of a 512 Hz square
    d.probe_oe = q.probe_on && !q.halt && !q.pre[`BRT_PROBE_BIT];
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ctrl <= `BRT_RST_CTRL;
      q.halt <= `BRT_RST_HALT;
      q.cnt.wday <= `BRT_RST_WDAY;
      q.cnt.date <= `BRT_RST_DATE;
      q.cnt.month <= `BRT_RST_MONTH;
      q.shadow.wday <= `BRT_RST_WDAY;
      q.shadow.date <= `BRT_RST_DATE;
      q.shadow.month <= `BRT_RST_MONTH;
      q.acc_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flops, except freq_probe_o tied to zero
  assign data_out = q.rd_data;
  assign data_oe = q.rd_oe;
  assign clk_hit = q.hit;
  assign freq_probe_o = 1'b0;
  assign freq_probe_oe = q.probe_oe;

endmodule : brt_top
`default_nettype wire

// File: testbench/brt_top_monitor.sv
// Port-level checks on the clock byte bus and register formats
`timescale 1ns/1ns
`default_nettype none
module brt_top_monitor (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire logic [12:0] addr, // Address
  input wire logic chip_en_n, // Enable
  input wire logic write_en_n, // Write strobe
  input wire logic out_en_n, // Read strobe
  input wire logic [7:0] data_out, // Read data
  input wire logic data_oe, // Read valid
  input wire logic clk_hit, // Byte hit
  input wire logic freq_probe_oe // Probe drive
);
  // Decode of a read into the clock bytes
  wire logic hit = addr[12:3] == 10'h3ff;
  wire logic rd = !chip_en_n && !out_en_n && write_en_n && hit;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Read answer one cycle late, silence otherwise
  property p_rd; rd |=> data_oe; endproperty
  a_rd: assert property (p_rd) else $error("no read data");
  property p_nrd; !rd |=> !data_oe && data_out == 8'h00; endproperty
  a_nrd: assert property (p_nrd) else $error("stray read data");
  property p_hit; !chip_en_n && hit |=> clk_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  property p_nhit; chip_en_n || !hit |=> !clk_hit; endproperty
  a_nhit: assert property (p_nhit) else $error("false hit");
  // Fixed zero bits and BCD range in read data
  property p_min; rd && addr[2:0] == 3'h2 |=> !data_out[7]; endproperty
  a_min: assert property (p_min) else $error("minute top bit");
  property p_hour; rd && addr[2:0] == 3'h3 |=> data_out[7:6] == 2'h0; endproperty
  a_hour: assert property (p_hour) else $error("hour top bits");
  property p_mon; rd && addr[2:0] == 3'h6 |=> data_out[7:5] == 3'h0; endproperty
  a_mon: assert property (p_mon) else $error("month top bits");
  property p_sec;
    rd && addr[2:0] == 3'h1 |=> data_out[6:4] < 3'h6 && data_out[3:0] < 4'ha;
  endproperty
  a_sec: assert property (p_sec) else $error("seconds not bcd");
  c_rd: cover property (rd ##1 data_oe);
  c_probe: cover property ($rose(freq_probe_oe));
  c_cen: cover property (rd && addr[2:0] == 3'h4 ##1 data_out[5]);
endmodule : brt_top_monitor
bind brt_top brt_top_monitor u_brt_top_monitor (.clock(clock), .reset_n(reset_n),
  .addr(addr), .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
  .data_out(data_out), .data_oe(data_oe), .clk_hit(clk_hit),
  .freq_probe_oe(freq_probe_oe));
`default_nettype wire

// File: testbench/brt_host.sv
// Host model issuing byte-wide memory cycles
`timescale 1ns/1ns
`default_nettype none
module brt_host (
  input wire logic clock, // Clock
  input wire logic [7:0] data_out, // Read data
  input wire logic data_oe, // Read valid
  output logic [12:0] addr, // Address
  output logic [7:0] data_in, // Write data
  output logic chip_en_n, // Enable
  output logic write_en_n, // Write strobe
  output logic out_en_n // Read strobe
);
  // Idle bus
  initial begin
    addr = 13'h0000;
    data_in = 8'h00;
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    out_en_n = 1'b1;
  end
  // Strobe one edge; released lines show inverted values, not stale ones
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 addr = a;
    data_in = d;
    chip_en_n = 1'b0;
    write_en_n = 1'b0;
    @(posedge clock);
    #1 chip_en_n = 1'b1;
    write_en_n = 1'b1;
    addr = ~a;
    data_in = ~d;
  endtask : wr
  // Request stands through the edge where the answer is sampled, released after
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    #1 addr = a;
    chip_en_n = 1'b0;
    out_en_n = 1'b0;
    repeat (2) @(posedge clock);
    d = data_out;
    v = data_oe;
    #1 chip_en_n = 1'b1;
    out_en_n = 1'b1;
    addr = ~a;
  endtask : rd
endmodule : brt_host
`default_nettype wire

// File: testbench/brt_top_tb.sv
// Self-checking bench for the real-time clock block
`timescale 1ns/1ns
`default_nettype none
module brt_top_tb;
  logic clock, reset_n, osc_pulse, vcc_good, batt_below, chip_en_n, write_en_n, out_en_n;
  logic [12:0] addr;
  logic [7:0] data_in, data_out, d;
  logic data_oe, clk_hit, freq_probe_o, freq_probe_oe, probe_q, v;
  int err_count = 0, n_tests = 0, n_flip = 0, cyc = 0, b;
  brt_top u_brt_top (.clock(clock), .reset_n(reset_n), .addr(addr), .data_in(data_in),
    .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
    .osc_pulse(osc_pulse), .vcc_good(vcc_good), .batt_below(batt_below),
    .data_out(data_out), .data_oe(data_oe), .clk_hit(clk_hit),
    .freq_probe_o(freq_probe_o), .freq_probe_oe(freq_probe_oe));
  brt_host u_brt_host (.clock(clock), .data_out(data_out), .data_oe(data_oe), .addr(addr),
    .data_in(data_in), .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Probe edge count and hang guard; one second costs 32768 cycles
  always @(posedge clock) begin
    probe_q <= freq_probe_oe;
    if (probe_q !== freq_probe_oe) n_flip <= n_flip + 1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk(input logic [12:0] a, input logic [7:0] e);
    u_brt_host.rd(a, d, v);
    cmp({v, d}, {1'b1, e});
  endtask : chk
  // All eight clock bytes, control in the low byte
  task automatic tbl(input logic [63:0] e);
    for (int i = 0; i < 8; i++) chk(13'h1ff8 + 13'(i), e[8*i+:8]);
  endtask : tbl
  // Oscillator ticks back to back, one per clock, to keep seconds affordable
  task automatic osc(input int n);
    @(posedge clock);
    #1 osc_pulse = 1'b1;
    repeat (n) @(posedge clock);
    #1 osc_pulse = 1'b0;
  endtask : osc
  task automatic power_cycle();
    @(posedge clock);
    #1 vcc_good = 1'b0;
    repeat (3) @(posedge clock);
    #1 vcc_good = 1'b1;
  endtask : power_cycle
  task automatic t_access();
    tbl(64'h0001_0101_0000_8000);
    u_brt_host.rd(13'h1ff0, d, v);
    cmp({v, d}, 9'h000);
    u_brt_host.wr(13'h1ffc, 8'h11);
    chk(13'h1ffc, 8'h01);
    u_brt_host.wr(13'h1ffc, 8'h21);
    chk(13'h1ffc, 8'h21);
  endtask : t_access
  task automatic t_batt();
    u_brt_host.wr(13'h1ffd, 8'h41);
    chk(13'h1ffd, 8'h01);
    u_brt_host.wr(13'h1ffd, 8'h81);
    batt_below = 1'b1;
    chk(13'h1ffd, 8'h81);
    power_cycle();
    chk(13'h1ffd, 8'hc1);
    batt_below = 1'b0;
    chk(13'h1ffd, 8'hc1);
    power_cycle();
    chk(13'h1ffd, 8'h81);
  endtask : t_batt
  task automatic t_probe();
    u_brt_host.wr(13'h1ffc, 8'h41);
    b = n_flip;
    osc(64);
    cmp(9'(n_flip - b), 9'd0);
    u_brt_host.wr(13'h1ff9, 8'h00);
    // Restart rise kept out of the window; edges are counted two clocks late
    repeat (3) @(posedge clock);
    b = n_flip;
    osc(256);
    repeat (3) @(posedge clock);
    cmp(9'(n_flip - b), 9'd8);
  endtask : t_probe
  // Load the last second of a century, freeze across the rollover, then trim
  task automatic t_roll();
    logic [63:0] tv;
    tv = 64'h9912_3137_2359_5940;
    u_brt_host.wr(13'h1ff8, 8'h80);
    for (int i = 1; i < 8; i++) u_brt_host.wr(13'h1ff8 + 13'(i), tv[8*i+:8]);
    u_brt_host.wr(13'h1ff8, 8'h00);
    osc(32767);
    chk(13'h1ff9, 8'h59);
    u_brt_host.wr(13'h1ff8, 8'h40);
    osc(1);
    tbl(tv);
    // One slow trim step: second 00 of this minute runs 256 pulses longer
    u_brt_host.wr(13'h1ff8, 8'h01);
    osc(32768);
    chk(13'h1ff9, 8'h59);
    osc(256);
    tbl(64'h0001_0121_0000_0101);
  endtask : t_roll
  task automatic report_and_stop();
    $display("errors %0d tests %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Reset, then the scenarios in order
  initial begin
    reset_n = 1'b0;
    osc_pulse = 1'b0;
    vcc_good = 1'b1;
    batt_below = 1'b0;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    t_access();
    t_batt();
    t_probe();
    t_roll();
    report_and_stop();
  end
endmodule : brt_top_tb
`default_nettype wire
